// ==== logic/ipc_regs.vh ====
// constants of the pin configuration register bank
// assumes the bank is decoded at its base by the system bus fabric
`ifndef IPC_REGS_VH
`define IPC_REGS_VH

// ***************************************************************
// address map
// ***************************************************************
`define IPC_BASE_ADDR 32'hfffe5000
`define IPC_ADDR_W 12
`define IPC_OFS_EBI_SEL 12'h000
`define IPC_OFS_PD_SEL 12'h004
`define IPC_OFS_PE_SEL 12'h008
`define IPC_OFS_TMR_SEL 12'h00c
`define IPC_OFS_DISP_SEL 12'h010
`define IPC_OFS_PA_PULL 12'h014
`define IPC_OFS_PB_PULL 12'h018
`define IPC_OFS_PC_PULL 12'h01c
`define IPC_OFS_PD_PULL 12'h020
`define IPC_OFS_PE_PULL 12'h024
`define IPC_OFS_ADC_SEL 12'h028

// ***************************************************************
// field widths
// ***************************************************************
`define IPC_EBI_W 15
`define IPC_PD_W 11
`define IPC_REG16_W 16
`define IPC_DISP_MODE_W 2
`define IPC_DISP_PINS 16
`define IPC_PD_PINS 7
`define IPC_DATA_BIT 14

// ***************************************************************
// reset values
// ***************************************************************
`define IPC_RST_EBI_16BIT 15'h4000
`define IPC_RST_EBI_8BIT 15'h0000
`define IPC_RST_PD_SEL 11'h000
`define IPC_RST_SEL16 16'h0000
`define IPC_RST_PA_PULL 16'haaaa
`define IPC_RST_PB_PULL 16'h0555
`define IPC_RST_PC_PULL 16'h0000
`define IPC_RST_PD_PULL 16'h095a
`define IPC_RST_PE_PULL 16'h4455

// ***************************************************************
// display modes and port d codes
// ***************************************************************
`define IPC_DISP_GPIO 2'h0
`define IPC_DISP_NARROW 2'h1
`define IPC_DISP_WIDE 2'h2
`define IPC_DISP_FULL 2'h3
`define IPC_MASK_NARROW 16'h00ff
`define IPC_MASK_WIDE 16'h0fff
`define IPC_MASK_FULL 16'hffff
`define IPC_MASK_NONE 16'h0000
`define IPC_PD_GPIO 2'h0
`define IPC_PD_RSTCOND 2'h3

`endif

// ==== logic/ipc_disp_decode.v ====
// display mode to display pin ownership decoder
// assumes a registered mode input; purely combinational
`timescale 1ns/1ps
`include "ipc_regs.vh"

module ipc_disp_decode (
   // mode in
   input wire [`IPC_DISP_MODE_W-1:0] i_mode,
   // per pin ownership, 1 = display controller
   output reg [`IPC_DISP_PINS-1:0] o_disp_own
);

   // ***************************************************************
   // mode decode
   // ***************************************************************
   // pins are granted by mode, never one by one [RULE6]
   always @*
   begin
      case (i_mode)
         `IPC_DISP_GPIO: o_disp_own = `IPC_MASK_NONE;
         `IPC_DISP_NARROW: o_disp_own = `IPC_MASK_NARROW;
         `IPC_DISP_WIDE: o_disp_own = `IPC_MASK_WIDE;
         `IPC_DISP_FULL: o_disp_own = `IPC_MASK_FULL;
         default: o_disp_own = `IPC_MASK_NONE;
      endcase
   end

endmodule

// ==== logic/ipc_io_pin_config.v ====
// pin configuration register bank: apb slave holding pin selects,
// display mode and pull resistor controls
// assumes base address decode upstream and a boot width strap
// that is stable around reset release
//
// Behaviour
// [RULE1] apb slave; every control register readable and writable
// [RULE2] master uses full word accesses only
// [RULE3] after reset gpio owns every shared pin except data bit 14; in 8-bit boot the code gives bit 14 to gpio too
// [RULE4] external bus select resets to 0x4000 in 16-bit boot else 0
// [RULE5] alternate function applies only once its select is programmed
// [RULE6] display register takes a mode, mode decides pin ownership
// [RULE7] five pull registers with per-pin function defaults
// [RULE8] registers at base 0xfffe5000, offsets 0x00 to 0x28 by four
// [RULE9] port d/e, timer, display, analog selects reset to zero
// [RULE10] port a, b, c pull registers reset 0xaaaa, 0x0555, 0x0000
// [RULE11] port d pull resets 0x095a, port e pull resets 0x4455
// [RULE12] writing the reset-condition code gives the post-reset setting
// [RULE13] external bus bits route to bus when set; 31:15 read only
// [RULE14] reserved bits read zero and writes to them do nothing
`timescale 1ns/1ps
`include "ipc_regs.vh"

module ipc_io_pin_config (
   // clock and reset
   input wire i_clk,
   input wire i_rst,
   // boot strap, high for 16-bit boot
   input wire i_boot_16bit,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [`IPC_ADDR_W-1:0] i_paddr,
   input wire [31:0] i_pwdata,
   output wire [31:0] o_prdata,
   output wire o_pready,
   output wire o_pslverr,
   // pin selects
   output wire [`IPC_EBI_W-1:0] o_ebi_sel,
   output wire [2*`IPC_PD_PINS-1:0] o_port_d_func,
   output wire [`IPC_REG16_W-1:0] o_port_e_sel,
   output wire [`IPC_REG16_W-1:0] o_timer_sel,
   output wire [`IPC_DISP_PINS-1:0] o_disp_own,
   output wire [`IPC_REG16_W-1:0] o_adc_sel,
   // pull controls
   output wire [`IPC_REG16_W-1:0] o_port_a_pull,
   output wire [`IPC_REG16_W-1:0] o_port_b_pull,
   output wire [`IPC_REG16_W-1:0] o_port_c_pull,
   output wire [`IPC_REG16_W-1:0] o_port_d_pull,
   output wire [`IPC_REG16_W-1:0] o_port_e_pull
);

   // ***************************************************************
   // functions
   // ***************************************************************
   // code 11 is the reset condition and behaves as 00
   function [1:0] pd_code;
      input [1:0] raw;
      begin
         if (raw == `IPC_PD_RSTCOND)
            pd_code = `IPC_PD_GPIO; // [RULE12]
         else
            pd_code = raw;
      end
   endfunction

   // full word, aligned, inside the map
   function is_hit;
      input [`IPC_ADDR_W-1:0] a;
      input [`IPC_ADDR_W-1:0] ofs;
      begin
         is_hit = (a == ofs);
      end
   endfunction

   // ***************************************************************
   // registers
   // ***************************************************************
   reg [`IPC_EBI_W-1:0] ebi_q;
   reg [`IPC_PD_W-1:0] pd_sel_q;
   reg [`IPC_REG16_W-1:0] pe_sel_q;
   reg [`IPC_REG16_W-1:0] tmr_sel_q;
   reg [`IPC_DISP_MODE_W-1:0] disp_mode_q;
   reg [`IPC_REG16_W-1:0] pa_pull_q;
   reg [`IPC_REG16_W-1:0] pb_pull_q;
   reg [`IPC_REG16_W-1:0] pc_pull_q;
   reg [`IPC_REG16_W-1:0] pd_pull_q;
   reg [`IPC_REG16_W-1:0] pe_pull_q;
   reg [`IPC_REG16_W-1:0] adc_sel_q;
   reg strap_done_q;
   reg [31:0] prdata_q;
   reg [31:0] prdata_d;
   reg pready_q;
   reg pslverr_q;
   reg hit_d;
   reg [`IPC_DISP_PINS-1:0] disp_own_q;
   reg [2*`IPC_PD_PINS-1:0] pd_func_q;
   reg [2*`IPC_PD_PINS-1:0] pd_func_d;
   wire [`IPC_DISP_PINS-1:0] disp_own_d;
   wire setup;
   wire wr;
   integer k;

   assign setup = i_psel & ~i_penable;
   // writes land in the access phase; no wait states are ever added
   assign wr = i_psel & i_penable & i_pwrite; // [RULE1]

   // ***************************************************************
   // read mux and decode
   // ***************************************************************
   // offsets are full byte addresses; low two bits must be zero [RULE8]
   // unused upper bits are padded with zero on read [RULE14]
   always @*
   begin
      prdata_d = 32'h0000_0000;
      hit_d = 1'b1;
      if (is_hit(i_paddr, `IPC_OFS_EBI_SEL))
         prdata_d[`IPC_EBI_W-1:0] = ebi_q; // [RULE13]
      else if (is_hit(i_paddr, `IPC_OFS_PD_SEL))
         prdata_d[`IPC_PD_W-1:0] = pd_sel_q;
      else if (is_hit(i_paddr, `IPC_OFS_PE_SEL))
         prdata_d[`IPC_REG16_W-1:0] = pe_sel_q;
      else if (is_hit(i_paddr, `IPC_OFS_TMR_SEL))
         prdata_d[`IPC_REG16_W-1:0] = tmr_sel_q;
      else if (is_hit(i_paddr, `IPC_OFS_DISP_SEL))
         prdata_d[`IPC_DISP_MODE_W-1:0] = disp_mode_q;
      else if (is_hit(i_paddr, `IPC_OFS_PA_PULL))
         prdata_d[`IPC_REG16_W-1:0] = pa_pull_q;
      else if (is_hit(i_paddr, `IPC_OFS_PB_PULL))
         prdata_d[`IPC_REG16_W-1:0] = pb_pull_q;
      else if (is_hit(i_paddr, `IPC_OFS_PC_PULL))
         prdata_d[`IPC_REG16_W-1:0] = pc_pull_q;
      else if (is_hit(i_paddr, `IPC_OFS_PD_PULL))
         prdata_d[`IPC_REG16_W-1:0] = pd_pull_q;
      else if (is_hit(i_paddr, `IPC_OFS_PE_PULL))
         prdata_d[`IPC_REG16_W-1:0] = pe_pull_q;
      else if (is_hit(i_paddr, `IPC_OFS_ADC_SEL))
         prdata_d[`IPC_REG16_W-1:0] = adc_sel_q;
      else
         hit_d = 1'b0;
   end

   // ***************************************************************
   // apb response
   // ***************************************************************
   // read data and error are staged in the setup phase so that
   // every bus output comes straight from a flop
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
         pready_q <= 1'b0;
      end
      else
      begin
         pready_q <= 1'b1;
         if (setup)
         begin
            prdata_q <= i_pwrite ? 32'h0000_0000 : prdata_d; // [RULE1]
            pslverr_q <= ~hit_d;
         end
         else if (~i_psel)
         begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // register writes
   // ***************************************************************
   // the strap is taken on the first edge after release, not under
   // the asynchronous reset; a bus write cannot occur that early
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ebi_q <= `IPC_RST_EBI_8BIT; // [RULE3]
         strap_done_q <= 1'b0;
         pd_sel_q <= `IPC_RST_PD_SEL; // [RULE9]
         pe_sel_q <= `IPC_RST_SEL16; // [RULE9]
         tmr_sel_q <= `IPC_RST_SEL16; // [RULE9]
         disp_mode_q <= `IPC_DISP_GPIO; // [RULE9]
         adc_sel_q <= `IPC_RST_SEL16; // [RULE9]
         pa_pull_q <= `IPC_RST_PA_PULL; // [RULE10] [RULE7]
         pb_pull_q <= `IPC_RST_PB_PULL; // [RULE10]
         pc_pull_q <= `IPC_RST_PC_PULL; // [RULE10]
         pd_pull_q <= `IPC_RST_PD_PULL; // [RULE11]
         pe_pull_q <= `IPC_RST_PE_PULL; // [RULE11]
      end
      else if (~strap_done_q)
      begin
         strap_done_q <= 1'b1;
         ebi_q <= i_boot_16bit ? `IPC_RST_EBI_16BIT
                               : `IPC_RST_EBI_8BIT; // [RULE4]
      end
      // only full words exist on this bus; upper bits are dropped
      else if (wr) // [RULE2]
      begin
         if (is_hit(i_paddr, `IPC_OFS_EBI_SEL))
            ebi_q <= i_pwdata[`IPC_EBI_W-1:0]; // [RULE13] [RULE5]
         if (is_hit(i_paddr, `IPC_OFS_PD_SEL))
            pd_sel_q <= i_pwdata[`IPC_PD_W-1:0]; // [RULE14]
         if (is_hit(i_paddr, `IPC_OFS_PE_SEL))
            pe_sel_q <= i_pwdata[`IPC_REG16_W-1:0];
         if (is_hit(i_paddr, `IPC_OFS_TMR_SEL))
            tmr_sel_q <= i_pwdata[`IPC_REG16_W-1:0];
         if (is_hit(i_paddr, `IPC_OFS_DISP_SEL))
            disp_mode_q <= i_pwdata[`IPC_DISP_MODE_W-1:0]; // [RULE6]
         if (is_hit(i_paddr, `IPC_OFS_PA_PULL))
            pa_pull_q <= i_pwdata[`IPC_REG16_W-1:0]; // [RULE7]
         if (is_hit(i_paddr, `IPC_OFS_PB_PULL))
            pb_pull_q <= i_pwdata[`IPC_REG16_W-1:0]; // [RULE7]
         if (is_hit(i_paddr, `IPC_OFS_PC_PULL))
            pc_pull_q <= i_pwdata[`IPC_REG16_W-1:0]; // [RULE7]
         if (is_hit(i_paddr, `IPC_OFS_PD_PULL))
            pd_pull_q <= i_pwdata[`IPC_REG16_W-1:0]; // [RULE7]
         if (is_hit(i_paddr, `IPC_OFS_PE_PULL))
            pe_pull_q <= i_pwdata[`IPC_REG16_W-1:0]; // [RULE7]
         if (is_hit(i_paddr, `IPC_OFS_ADC_SEL))
            adc_sel_q <= i_pwdata[`IPC_REG16_W-1:0];
      end
   end

   // ***************************************************************
   // pin ownership
   // ***************************************************************
   ipc_disp_decode u_disp (
      .i_mode (disp_mode_q),
      .o_disp_own (disp_own_d)
   );

   // port d: two bits per pin, seven pins, reset code folded to gpio
   always @*
   begin
      pd_func_d = {2*`IPC_PD_PINS{1'b0}};
      for (k = 0; k < `IPC_PD_PINS - 4; k = k + 1)
         pd_func_d[2*k +: 2] = {1'b0, pd_sel_q[k]};
      for (k = 0; k < 4; k = k + 1)
         pd_func_d[2*(k+3) +: 2] = pd_code(pd_sel_q[3+2*k +: 2]); // [RULE12]
   end

   // decoded ownership is registered: one cycle behind the register,
   // which keeps pin muxes glitch free after a write
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         disp_own_q <= `IPC_MASK_NONE; // [RULE3]
         pd_func_q <= {2*`IPC_PD_PINS{1'b0}}; // [RULE5]
      end
      else
      begin
         disp_own_q <= disp_own_d; // [RULE6]
         pd_func_q <= pd_func_d; // [RULE5]
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_ebi_sel = ebi_q;
   assign o_port_d_func = pd_func_q;
   assign o_port_e_sel = pe_sel_q;
   assign o_timer_sel = tmr_sel_q;
   assign o_disp_own = disp_own_q;
   assign o_adc_sel = adc_sel_q;
   assign o_port_a_pull = pa_pull_q;
   assign o_port_b_pull = pb_pull_q;
   assign o_port_c_pull = pc_pull_q;
   assign o_port_d_pull = pd_pull_q;
   assign o_port_e_pull = pe_pull_q;

endmodule

// ==== dv/ipc_apb_mst.sv ====
// apb master model driving the pin configuration bank
// assumes one clock; requests change 1 ns after the rising edge
`timescale 1ns/1ps
module ipc_apb_mst (
   // bus answer
   input wire i_clk,
   input wire i_pready,
   input wire [31:0] i_prdata,
   input wire i_pslverr,
   // bus request
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [11:0] o_paddr,
   output logic [31:0] o_pwdata
);
   initial
   begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 12'h000;
      o_pwdata = 32'h0;
   end
   // full 32-bit words only, no byte lanes exist
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      integer n;
      begin
         @(posedge i_clk);
         #1;
         o_psel = 1'b1;
         o_pwrite = w;
         o_paddr = a;
         o_pwdata = d;
         @(posedge i_clk);
         #1;
         o_penable = 1'b1;
         n = 0;
         @(posedge i_clk);
         while (i_pready !== 1'b1 && n < 16)
         begin
            n = n + 1;
            @(posedge i_clk);
         end
         r = i_prdata;
         e = i_pslverr;
         #1;
         o_psel = 1'b0;
         o_penable = 1'b0;
         // released lines show stale inverse, not a friendly value
         o_paddr = ~a;
         o_pwdata = ~d;
      end
   endtask
endmodule

// ==== dv/ipc_chk_chk.sv ====
// port level checker for the pin configuration bank
// assumes single clock domain and async active-high reset
`timescale 1ns/1ps
`include "ipc_regs.vh"
module ipc_chk (
   input wire i_clk, input wire i_rst, input wire i_boot_16bit,
   input wire i_psel, input wire i_penable, input wire i_pwrite,
   input wire [11:0] i_paddr, input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata, input wire o_pready, input wire o_pslverr,
   input wire [14:0] o_ebi_sel, input wire [13:0] o_port_d_func,
   input wire [15:0] o_disp_own, input wire [15:0] o_port_a_pull
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire acc = i_psel & i_penable;
   wire wr = acc & i_pwrite;
   wire bad = (i_paddr > `IPC_OFS_ADC_SEL) | (|i_paddr[1:0]);
   function [13:0] pdf(input [31:0] d);
      integer k;
      begin
         pdf = {8'h00, 1'b0, d[2], 1'b0, d[1], 1'b0, d[0]};
         // code 11 is the reset condition, so it reads as gpio
         for (k = 3; k < 7; k = k + 1)
            pdf[2*k +: 2] = (d[2*k-3 +: 2] == 2'h3) ? 2'h0 : d[2*k-3 +: 2];
      end
   endfunction
   function [15:0] dm(input [31:0] d);
      dm = d[1] ? (d[0] ? 16'hffff : 16'h0fff) : (d[0] ? 16'h00ff : 16'h0);
   endfunction
   // ****
   // assertions
   // ****
   pready_on_a: assert property (!$past(i_rst) |-> o_pready)
      else $error("pready low after reset");
   idle_zero_a: assert property (!i_psel && !$past(i_psel) |->
      o_prdata == 32'h0 && !o_pslverr) else $error("idle bus not zero");
   bad_addr_a: assert property (acc && bad |-> o_pslverr
      && o_prdata == 32'h0) else $error("unmapped access not refused");
   good_addr_a: assert property (acc && !bad |-> !o_pslverr)
      else $error("mapped access refused");
   rsvd_zero_a: assert property (acc && !i_pwrite |->
      o_prdata[31:16] == 16'h0 && !(i_paddr == 12'h0 && o_prdata[15]))
      else $error("reserved bits not zero");
   boot_ebi_a: assert property ($fell(i_rst) |=>
      o_ebi_sel == ($past(i_boot_16bit) ? 15'h4000 : 15'h0))
      else $error("boot width reset wrong");
   rst_vals_a: assert property ($fell(i_rst) |->
      o_port_a_pull == 16'haaaa && o_disp_own == 16'h0
      && o_port_d_func == 14'h0) else $error("reset outputs wrong");
   pull_wr_a: assert property (wr && i_paddr == `IPC_OFS_PA_PULL |=>
      {16'h0, o_port_a_pull} == ($past(i_pwdata) & 32'hffff))
      else $error("pull write lost");
   ebi_wr_a: assert property (wr && i_paddr == 12'h0 |=>
      {17'h0, o_ebi_sel} == ($past(i_pwdata) & 32'h7fff))
      else $error("bus select write lost");
   disp_mode_a: assert property (wr
      && i_paddr == `IPC_OFS_DISP_SEL |-> ##2
      o_disp_own == dm($past(i_pwdata, 2))) else $error("display map");
   pd_func_a: assert property (wr && i_paddr == `IPC_OFS_PD_SEL |->
      ##2 o_port_d_func == pdf($past(i_pwdata, 2))) else $error("port d map");
   cov_disp_c: cover property (wr && i_paddr == 12'h010
      && i_pwdata[1:0] == 2'h3);
   cov_bad_c: cover property (acc && bad);
   cov_boot_c: cover property ($fell(i_rst) && !i_boot_16bit);
endmodule
bind ipc_io_pin_config ipc_chk u_chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_boot_16bit(i_boot_16bit), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_ebi_sel(o_ebi_sel), .o_port_d_func(o_port_d_func),
   .o_disp_own(o_disp_own), .o_port_a_pull(o_port_a_pull));

// ==== dv/testbench.sv ====
// self-checking bench for the pin configuration bank
// assumes the apb master model and the bound checker
`timescale 1ns/1ps
module testbench;
   typedef struct packed {logic [11:0] a; logic [31:0] w, e;
      logic r;} ipc_row_t;
   logic i_clk, i_rst, i_boot_16bit;
   wire i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   wire [11:0] i_paddr;
   wire [31:0] i_pwdata, o_prdata;
   wire [14:0] o_ebi_sel;
   wire [13:0] o_port_d_func;
   wire [15:0] pe, tm, dw, ad, pa, pb, pc, pd, pf;
   integer miscompares = 0, n_checks = 0, cyc = 0, k;
   logic [31:0] rd;
   logic er;
   ipc_row_t rows [0:12];
   logic [15:0] rstv [0:10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
      16'haaaa, 16'h0555, 16'h0, 16'h095a, 16'h4455, 16'h0};
   logic [15:0] msk [0:3] = '{16'h0, 16'h00ff, 16'h0fff, 16'hffff};
   ipc_io_pin_config uut (.i_clk(i_clk), .i_rst(i_rst),
      .i_boot_16bit(i_boot_16bit), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .o_ebi_sel(o_ebi_sel), .o_port_d_func(o_port_d_func),
      .o_port_e_sel(pe), .o_timer_sel(tm), .o_disp_own(dw), .o_adc_sel(ad),
      .o_port_a_pull(pa), .o_port_b_pull(pb), .o_port_c_pull(pc),
      .o_port_d_pull(pd), .o_port_e_pull(pf));
   ipc_apb_mst mst (.i_clk(i_clk), .i_pready(o_pready), .i_prdata(o_prdata),
      .i_pslverr(o_pslverr), .o_psel(i_psel), .o_penable(i_penable),
      .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata));
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // ****
   // tasks
   // ****
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task do_reset(input logic b);
      begin
         i_boot_16bit = b;
         i_rst = 1'b1;
         repeat (6) @(posedge i_clk);
         #1 i_rst = 1'b0;
         @(posedge i_clk);
      end
   endtask
   // a hang is cut short well past the expected 160 or so cycles
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         miscompares = miscompares + 1;
         give_verdict;
      end
   end
   // ****
   // main sequence
   // ****
   initial
   begin
      rows[0] = '{12'h000, 32'hffffffff, 32'h7fff, 1'b0};
      rows[1] = '{12'h004, 32'hffffffff, 32'h07ff, 1'b0};
      rows[2] = '{12'h008, 32'hffff1234, 32'h1234, 1'b0};
      rows[3] = '{12'h00c, 32'h12345678, 32'h5678, 1'b0};
      rows[4] = '{12'h010, 32'hfffffffe, 32'h0002, 1'b0};
      rows[5] = '{12'h014, 32'ha5a55a5a, 32'h5a5a, 1'b0};
      rows[6] = '{12'h018, 32'h0000c3c3, 32'hc3c3, 1'b0};
      rows[7] = '{12'h01c, 32'h80000001, 32'h0001, 1'b0};
      rows[8] = '{12'h020, 32'h0000ffff, 32'hffff, 1'b0};
      rows[9] = '{12'h024, 32'h00001111, 32'h1111, 1'b0};
      rows[10] = '{12'h028, 32'h0001000f, 32'h000f, 1'b0};
      rows[11] = '{12'h02c, 32'hffffffff, 32'h0, 1'b1};
      rows[12] = '{12'h006, 32'hffffffff, 32'h0, 1'b1};
      do_reset(1'b1);
      // strap lands on the first edge after release, so look just after it
      #1 chk({17'h0, o_ebi_sel}, 32'h4000);
      for (k = 0; k < 13; k = k + 1)
      begin
         mst.xfer(1'b1, rows[k].a, rows[k].w, rd, er);
         mst.xfer(1'b0, rows[k].a, 32'h0, rd, er);
         chk(rd, rows[k].e);
         chk({31'h0, er}, {31'h0, rows[k].r});
      end
      chk({pe, tm}, 32'h1234_5678);
      chk({pa, pb}, 32'h5a5a_c3c3);
      chk({pc, pd}, 32'h0001_ffff);
      chk({pf, ad}, 32'h1111_000f);
      $display("test register rows done");
      for (k = 0; k < 4; k = k + 1)
      begin
         mst.xfer(1'b1, 12'h010, k, rd, er);
         repeat (2) @(posedge i_clk);
         #1 chk({16'h0, dw}, {16'h0, msk[k]});
      end
      mst.xfer(1'b1, 12'h004, 32'h4e5, rd, er);
      repeat (2) @(posedge i_clk);
      #1 chk({18'h0, o_port_d_func}, 32'h2411);
      $display("test display and port d done");
      do_reset(1'b0);
      #1 chk({17'h0, o_ebi_sel}, 32'h0);
      chk({pe, tm}, 32'h0);
      chk({ad, dw}, 32'h0);
      chk({pa, pb}, 32'haaaa_0555);
      chk({pc, pd}, 32'h0000_095a);
      chk({pf, 2'h0, o_port_d_func}, 32'h4455_0000);
      for (k = 0; k < 11; k = k + 1)
      begin
         mst.xfer(1'b0, 4 * k, 32'h0, rd, er);
         chk(rd, {16'h0, rstv[k]});
      end
      do_reset(1'b1);
      mst.xfer(1'b0, 12'h000, 32'h0, rd, er);
      chk(rd, 32'h4000);
      $display("test reset values done");
      give_verdict;
   end
endmodule
